// ==== common/rstcause_pkg.sv ====
`default_nettype none
package rstcause_pkg;
    // ========================================================================
    // Bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ========================================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS      = 8'h8E;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hF0;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'hF1;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS      = {2'h0, IDX_FLAGS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = {2'h0, IDX_IRQ_MASK, 2'h0};

    // ========================================================================
    // Field layout of the reset-cause register
    localparam int FLAGS_W          = 2;
    localparam int BIT_BROWNOUT     = 0;
    localparam int BIT_POWERON      = 1;
    localparam logic [FLAGS_W-1:0] FLAGS_RST = 2'h0;

    // ========================================================================
    // Event layout shared by interrupt status and mask
    localparam int EVT_W            = 3;
    localparam int EVT_BROWNOUT     = 0;
    localparam int EVT_WATCHDOG     = 1;
    localparam int EVT_EXTPIN       = 2;
    localparam logic [EVT_W-1:0] IRQ_STATUS_RST = 3'h0;
    localparam logic [EVT_W-1:0] IRQ_MASK_RST   = 3'h0;

    // ========================================================================
    // Input synchroniser depth
    localparam int SYNC_STAGES = 3;

    // ========================================================================
    // Types
    typedef struct packed {
        logic              sel;
        logic              enable;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } apb_req_t;

    typedef enum logic [0:0] {
        APB_IDLE,
        APB_RESP
    } apb_state_t;
endpackage
`default_nettype wire

// ==== logic/reset_cause_status_register.sv ====
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE1: Flags held in static storage flip-flops
// RULE2: Flags tell power-on, brown-out, other resets apart
// RULE3: Reset-cause register at index 8Eh
// RULE4: Bits 7 to 2 read zero, writes ignored
// RULE5: Power-on clears bit 1 until software sets
// RULE6: Brown-out clears bit 0 until software sets
// RULE7: Watchdog and pin resets leave flags untouched
module reset_cause_status_register
    import rstcause_pkg::*;
(
    input  wire logic              CLK_SYS_IN,
    input  wire logic              SYS_RST_IN,
    input  wire logic              PSEL_IN,
    input  wire logic              PENABLE_IN,
    input  wire logic              PWRITE_IN,
    input  wire logic [ADDR_W-1:0] PADDR_IN,
    input  wire logic [DATA_W-1:0] PWDATA_IN,
    output var  logic [DATA_W-1:0] PRDATA_OUT,
    output var  logic              PREADY_OUT,
    output var  logic              PSLVERR_OUT,
    input  wire logic              BROWNOUT_DET_IN,
    input  wire logic              WATCHDOG_RESET_IN,
    input  wire logic              EXTERNAL_RESET_PIN_IN,
    output var  logic              IRQ_OUT
);

    // ========================================================================
    // Bus request bundle
    apb_req_t req;
    assign req = '{sel:    PSEL_IN,
                   enable: PENABLE_IN,
                   write:  PWRITE_IN,
                   addr:   PADDR_IN,
                   wdata:  PWDATA_IN};

    // ========================================================================
    // Event synchronisers
    // Detector pins are asynchronous; a change counts once stages two and three agree
    logic [EVT_W-1:0] pins;
    logic [EVT_W-1:0] s1_ff;
    logic [EVT_W-1:0] s2_ff;
    logic [EVT_W-1:0] s3_ff;
    logic [EVT_W-1:0] lvl_ff;
    logic [EVT_W-1:0] agree;
    logic [EVT_W-1:0] nxt_lvl;
    logic [EVT_W-1:0] evt;

    assign pins[EVT_BROWNOUT] = BROWNOUT_DET_IN;
    assign pins[EVT_WATCHDOG] = WATCHDOG_RESET_IN;
    assign pins[EVT_EXTPIN]   = EXTERNAL_RESET_PIN_IN;

    assign agree   = ~(s2_ff ^ s3_ff);
    assign nxt_lvl = (agree & s2_ff) | (~agree & lvl_ff);
    assign evt     = nxt_lvl & ~lvl_ff;

    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            lvl_ff <= '0;
        end else begin
            s1_ff  <= pins;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    logic bo_evt;
    logic wd_evt;
    logic pin_evt;
    assign bo_evt  = evt[EVT_BROWNOUT];
    assign wd_evt  = evt[EVT_WATCHDOG];
    assign pin_evt = evt[EVT_EXTPIN];

    // ========================================================================
    // APB slave sequencing
    // One wait state so that ready, read data and error all leave from flops
    apb_state_t        st_ff;
    apb_state_t        nxt_st;
    logic              access;
    logic              commit;
    logic              hit_flags;
    logic              hit_status;
    logic              hit_mask;
    logic              hit_any;

    assign access     = req.sel & req.enable;
    assign commit     = access & (st_ff == APB_RESP);
    assign hit_flags  = (req.addr == ADDR_FLAGS);
    assign hit_status = (req.addr == ADDR_IRQ_STATUS);
    assign hit_mask   = (req.addr == ADDR_IRQ_MASK);
    assign hit_any    = hit_flags | hit_status | hit_mask;
    assign nxt_st     = (access && st_ff == APB_IDLE) ? APB_RESP : APB_IDLE;

    logic wr_flags;
    logic wr_mask;
    logic rd_status;
    assign wr_flags  = commit & req.write & hit_flags; //RULE3
    assign wr_mask   = commit & req.write & hit_mask;
    assign rd_status = commit & ~req.write & hit_status;

    // ========================================================================
    // Reset-cause flags
    // Storage is plain flops so the value rides through watchdog and pin resets
    logic [FLAGS_W-1:0] flags_ff;
    logic [FLAGS_W-1:0] nxt_flags;
    logic [FLAGS_W-1:0] wr_val;

    assign wr_val = wr_flags ? req.wdata[FLAGS_W-1:0] : flags_ff; //RULE4
    // Detector clear beats a software set in the same cycle
    logic nxt_poweron;
    logic nxt_brownout;
    // Watchdog and pin events reach only the status register, never the flags
    assign nxt_poweron  = wr_val[BIT_POWERON]; //RULE7
    assign nxt_brownout = wr_val[BIT_BROWNOUT] & ~bo_evt; //RULE6
    assign nxt_flags    = {nxt_poweron, nxt_brownout};

    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            flags_ff <= FLAGS_RST; //RULE5
        end else begin
            flags_ff <= nxt_flags; //RULE1
        end
    end

    // ========================================================================
    // Interrupt status and mask
    logic [EVT_W-1:0] status_ff;
    logic [EVT_W-1:0] mask_ff;
    logic [EVT_W-1:0] nxt_status;
    logic [EVT_W-1:0] nxt_mask;
    logic [EVT_W-1:0] rd_clr;
    logic             irq_ff;

    // Only bits already returned are cleared, so a late event is never lost
    assign rd_clr     = rd_status ? PRDATA_OUT[EVT_W-1:0] : '0;
    assign nxt_status = (status_ff & ~rd_clr) | evt;
    assign nxt_mask   = wr_mask ? req.wdata[EVT_W-1:0] : mask_ff;

    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            status_ff <= IRQ_STATUS_RST;
            mask_ff   <= IRQ_MASK_RST;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status; //RULE2
            mask_ff   <= nxt_mask;
            irq_ff    <= |(nxt_status & nxt_mask);
        end
    end

    // ========================================================================
    // Read path and response flops
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic              capture;

    assign capture = access & (st_ff == APB_IDLE);
    assign rd_data = (hit_flags)  ? {{(DATA_W-FLAGS_W){1'b0}}, flags_ff} : //RULE4
                     (hit_status) ? {{(DATA_W-EVT_W){1'b0}}, status_ff} :
                     (hit_mask)   ? {{(DATA_W-EVT_W){1'b0}}, mask_ff} :
                     '0;

    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            st_ff      <= APB_IDLE;
            prdata_ff  <= '0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            st_ff      <= nxt_st;
            pready_ff  <= capture;
            pslverr_ff <= capture & ~hit_any;
            prdata_ff  <= (capture && !req.write) ? rd_data : '0;
        end
    end

    assign PRDATA_OUT  = prdata_ff;
    assign PREADY_OUT  = pready_ff;
    assign PSLVERR_OUT = pslverr_ff;
    assign IRQ_OUT     = irq_ff;

    // ========================================================================
    // Checks
    logic seen_ff;
    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            seen_ff <= 1'b0;
        end else begin
            seen_ff <= 1'b1;
        end
    end

    AST_FLAGS_HOLD: assert property ( //RULE1
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (!wr_flags && !bo_evt) |=> $stable(flags_ff))
        else $error("Flags changed with no write and no brown-out");

    AST_FLAGS_READBACK: assert property ( //RULE2
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (capture && !req.write && hit_flags) |=> (PRDATA_OUT[FLAGS_W-1:0] == $past(flags_ff))
        && PREADY_OUT)
        else $error("Flag read returned wrong value");

    AST_MAP_FLAGS: assert property ( //RULE3
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (capture && hit_flags) |=> PREADY_OUT && !PSLVERR_OUT)
        else $error("Reset-cause register not answered at its address");

    AST_UPPER_ZERO: assert property ( //RULE4
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (commit && hit_flags) |-> (PRDATA_OUT[DATA_W-1:FLAGS_W] == '0))
        else $error("Unimplemented flag bits read nonzero");

    AST_POWERON_CLEAR: assert property ( //RULE5
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !seen_ff |-> (flags_ff[BIT_POWERON] == 1'b0))
        else $error("Power-on flag not zero after power-on");

    AST_POWERON_STAY: assert property ( //RULE5
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (!flags_ff[BIT_POWERON] && !wr_flags) |=> !flags_ff[BIT_POWERON])
        else $error("Power-on flag set without software write");

    AST_BROWNOUT_CLEAR: assert property ( //RULE6
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        $rose(lvl_ff[EVT_BROWNOUT]) |-> !flags_ff[BIT_BROWNOUT] && status_ff[EVT_BROWNOUT])
        else $error("Brown-out did not clear flag and raise status");

    AST_OTHER_RESETS: assert property ( //RULE7
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        ((wd_evt || pin_evt) && !bo_evt && !wr_flags) |=> $stable(flags_ff)
        ##0 (status_ff[EVT_WATCHDOG] || status_ff[EVT_EXTPIN]))
        else $error("Watchdog or pin reset disturbed the flags");

    AST_PREADY_PULSE: assert property (
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        PREADY_OUT |=> !PREADY_OUT)
        else $error("Ready held longer than one cycle");

    AST_IRQ_LEVEL: assert property (
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        IRQ_OUT == |(status_ff & mask_ff))
        else $error("Interrupt output disagrees with status and mask");

    AST_FLAGS_WRITE: assert property ( //RULE5
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (wr_flags && !bo_evt) |=> (flags_ff == $past(PWDATA_IN[FLAGS_W-1:0])))
        else $error("Flag write did not land");

    AST_BROWNOUT_WINS: assert property ( //RULE6
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        bo_evt |=> !flags_ff[BIT_BROWNOUT])
        else $error("Brown-out flag survived a brown-out event");

    AST_BROWNOUT_STAY: assert property ( //RULE6
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (!flags_ff[BIT_BROWNOUT] && !wr_flags) |=> !flags_ff[BIT_BROWNOUT])
        else $error("Brown-out flag set without software write");

    AST_PSLVERR_UNMAPPED: assert property ( //RULE3
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (capture && !hit_any) |=> (PREADY_OUT && PSLVERR_OUT && (PRDATA_OUT == '0)))
        else $error("Unmapped access not refused");

    AST_PSLVERR_MAPPED: assert property ( //RULE3
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (capture && hit_any) |=> !PSLVERR_OUT)
        else $error("Mapped access refused");

    AST_IDLE_OUTPUTS: assert property (
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !PREADY_OUT |-> ((PRDATA_OUT == '0) && !PSLVERR_OUT))
        else $error("Read data or error shown outside a ready cycle");

    AST_READY_ONE_WAIT: assert property (
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        capture |=> PREADY_OUT)
        else $error("Ready did not follow the first access cycle");

    AST_READY_ONLY_ON_ACCESS: assert property (
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !capture |=> !PREADY_OUT)
        else $error("Ready raised without an access cycle");

    AST_STATUS_STICKY: assert property ( //RULE2
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !rd_status |=> ((status_ff & $past(status_ff)) == $past(status_ff)))
        else $error("Status bit dropped without a status read");

    AST_STATUS_SET: assert property ( //RULE2
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (|evt) |=> ((status_ff & $past(evt)) == $past(evt)))
        else $error("Event did not set its status bit");

    AST_STATUS_NO_WRITE: assert property ( //RULE2
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        (commit && req.write && hit_status && !(|evt)) |=> $stable(status_ff))
        else $error("Status register changed by a write");

    AST_MASK_WRITE: assert property (
        @(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        wr_mask |=> (mask_ff == $past(PWDATA_IN[EVT_W-1:0])))
        else $error("Mask write did not land");

endmodule
`default_nettype wire

// ==== dv/reset_cause_status_register_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module reset_cause_status_register_tb_top
    import rstcause_pkg::*;
;
    // ========================================================================
    // Stimulus signals
    logic              clk_sys = 1'b0;
    logic              sys_rst = 1'b1;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [ADDR_W-1:0] paddr   = '0;
    logic [DATA_W-1:0] pwdata  = '0;
    logic [EVT_W-1:0]  ev      = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic [DATA_W-1:0] rd;
    logic              er;
    int                num_errors = 0;
    int                n_tests    = 0;

    reset_cause_status_register i_reset_cause_status_register (
        .CLK_SYS_IN            (clk_sys),
        .SYS_RST_IN            (sys_rst),
        .PSEL_IN               (psel),
        .PENABLE_IN            (penable),
        .PWRITE_IN             (pwrite),
        .PADDR_IN              (paddr),
        .PWDATA_IN             (pwdata),
        .PRDATA_OUT            (prdata),
        .PREADY_OUT            (pready),
        .PSLVERR_OUT           (pslverr),
        .BROWNOUT_DET_IN       (ev[EVT_BROWNOUT]),
        .WATCHDOG_RESET_IN     (ev[EVT_WATCHDOG]),
        .EXTERNAL_RESET_PIN_IN (ev[EVT_EXTPIN]),
        .IRQ_OUT               (irq)
    );

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ========================================================================
    // Tasks
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Request stands until the edge that samples ready high; the answer is taken at that edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        bit done;
        done = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) begin
                rd   = prdata;
                er   = pslverr;
                done = 1;
            end
        end
        if (!done) begin
            num_errors++;
            report_and_stop();
        end else begin
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        apb(1'b0, a, '0);
        `CHK(er, 1'b0)
        `CHK(rd, e)
    endtask

    // Detector levels pass a synchroniser, so hold them well past its depth
    task automatic pulse(input int k);
        @(posedge clk_sys);
        ev[k] <= 1'b1;
        repeat (8) @(posedge clk_sys);
        ev[k] <= 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask

    // ========================================================================
    // Sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rchk(ADDR_FLAGS, 32'h0000_0000);
        rchk(ADDR_IRQ_STATUS, 32'h0000_0000);
        rchk(ADDR_IRQ_MASK, 32'h0000_0000);
        endt("reset");
        apb(1'b1, ADDR_FLAGS, 32'hFFFF_FFFF);
        rchk(ADDR_FLAGS, 32'h0000_0003);
        apb(1'b1, ADDR_FLAGS, 32'h0000_0001);
        rchk(ADDR_FLAGS, 32'h0000_0001);
        apb(1'b1, ADDR_FLAGS, 32'h0000_0003);
        endt("flags");
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0007);
        pulse(EVT_WATCHDOG);
        `CHK(irq, 1'b1)
        rchk(ADDR_FLAGS, 32'h0000_0003);
        rchk(ADDR_IRQ_STATUS, 32'h0000_0002);
        rchk(ADDR_IRQ_STATUS, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(irq, 1'b0)
        pulse(EVT_EXTPIN);
        rchk(ADDR_FLAGS, 32'h0000_0003);
        rchk(ADDR_IRQ_STATUS, 32'h0000_0004);
        endt("other_resets");
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
        pulse(EVT_BROWNOUT);
        `CHK(irq, 1'b0)
        rchk(ADDR_FLAGS, 32'h0000_0002);
        rchk(ADDR_IRQ_STATUS, 32'h0000_0001);
        endt("brownout");
        apb(1'b0, 12'h100, '0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, ADDR_FLAGS + 12'h001, 32'h0000_0003);
        `CHK(er, 1'b1)
        rchk(ADDR_FLAGS, 32'h0000_0002);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0007);
        rchk(ADDR_IRQ_STATUS, 32'h0000_0000);
        endt("decode");
        apb(1'b1, ADDR_FLAGS, 32'h0000_0003);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rchk(ADDR_FLAGS, 32'h0000_0000);
        endt("power_on");
        report_and_stop();
    end
endmodule
`undef CHK
`default_nettype wire
